//--- rtl/flow_pkg.sv
package flow_pkg;

	// data widths
	localparam int CNT_W  = 48;                  // total and batcher counters
	localparam int RATE_W = 24;                  // flow rate and period values
	localparam int CUR_W  = 15;                  // input current in microamps
	localparam int INC_W  = 16;                  // volume added per sample
	localparam int BCNT_W = 16;                  // number of batches counter
	localparam int TMR_W  = 28;                  // width of the long timers

	// six display digits
	localparam logic [RATE_W-1:0] SIX_DIG_MAX = 24'hF423F;        // 999999
	localparam logic [CNT_W-1:0]  SCREEN_LIM1 = 48'h0000000F4240; // 10^6
	localparam logic [CNT_W-1:0]  SCREEN_LIM2 = 48'h00E8D4A51000; // 10^12
	localparam logic [1:0]        SCREEN_TOP  = 2'h2;

	// cutoff threshold in microamps
	localparam logic [15:0] CUT_SPAN_020 = 16'h00C8;  // 20 mA / 100
	localparam logic [15:0] CUT_SPAN_420 = 16'h00A0;  // 16 mA / 100
	localparam logic [15:0] CUT_BASE_420 = 16'h0FA0;  // 4 mA

	// times and the cycle counts derived from them
	localparam int CLK_HZ      = 50_000_000;
	localparam int QV_TIME_MS  = 5000;           // quick view window
	localparam int HOLD_MS     = 2000;           // totals button hold
	localparam int BLINK_MS    = 500;            // flash half period
	localparam int TENTH_MS    = 100;            // unit of the show time
	localparam int QV_CYC_DEF    = (CLK_HZ / 1000) * QV_TIME_MS;
	localparam int HOLD_CYC_DEF  = (CLK_HZ / 1000) * HOLD_MS;
	localparam int BLINK_CYC_DEF = (CLK_HZ / 1000) * BLINK_MS;
	localparam int TENTH_CYC_DEF = (CLK_HZ / 1000) * TENTH_MS;

	// what the measurement display shows
	typedef enum logic [1:0] {
		V_RATE  = 2'b00,
		V_TOTAL = 2'b01,
		V_BATCH = 2'b10
	} view_t;

	// message shown instead of a number
	typedef enum logic [3:0] {
		M_VALUE     = 4'b0000,
		M_STOP      = 4'b0001,
		M_POVER     = 4'b0010,   // period_over_msg
		M_PUNDER    = 4'b0011,   // period_under_msg
		M_RHIGH     = 4'b0100,   // range_high_msg
		M_RLOW      = 4'b0101,   // range_low_msg
		M_TOVF      = 4'b0110,   // total_overflow_msg
		M_BOVF      = 4'b0111,   // batcher_overflow_msg
		M_THR1_LBL  = 4'b1000,   // threshold_one_label
		M_BCNT_LBL  = 4'b1001,   // batch_count_label
		M_CLEAR_Q   = 4'b1010    // clear confirmation query
	} msg_t;

	// static configuration
	typedef struct packed {
		logic               period_mode;
		logic               range_4_20;
		logic [6:0]         cutoff_pct;
		logic               batcher_source;
		logic               button_clear_enable_tot;
		logic               button_clear_enable_bat;
		logic               peak_display_style;   // 1: hold, 0: real
		logic [RATE_W-1:0]  peak_min_swing;
		logic [7:0]         peak_show_tenths;
	} cfg_t;

	// one measurement sample
	typedef struct packed {
		logic               sample_valid;
		logic [CUR_W-1:0]   current_ua;
		logic [RATE_W-1:0]  flow_rate;
		logic [RATE_W-1:0]  period_value;
		logic [INC_W-1:0]   flow_increment;
		logic               range_high;
		logic               range_low;
	} meas_t;

	// front panel buttons, levels
	typedef struct packed {
		logic total;
		logic enter;
		logic up;
		logic down;
		logic esc;
	} btn_t;

	// display content
	typedef struct packed {
		msg_t              msg;
		logic [CNT_W-1:0]  value;
		logic [1:0]        screen;
		logic              dp_left;
		logic              dp_right;
		logic              total_led;
	} disp_t;

endpackage

//--- rtl/sat_counter.sv
`timescale 1ns/10ps
module sat_counter
	import flow_pkg::*;
#(
	parameter int W  = CNT_W,
	parameter int IW = INC_W
)
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// control
	input  wire logic          inc_en,
	input  wire logic [IW-1:0] inc_amt,
	input  wire logic          clr,
	// state
	output logic      [W-1:0]  count,
	output logic               ovf
);

	if (IW >= W)
		$error("increment wider than counter");

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         ovf;
	} sc_t;

	sc_t          s_r;
	sc_t          s_nxt;
	logic [W:0]   sum;   // one bit of headroom to see the overflow

	assign sum = {1'b0, s_r.cnt} + {{(W+1-IW){1'b0}}, inc_amt};

	// saturating accumulate; a sample in the clearing cycle is kept
	always_comb
	begin
		s_nxt = s_r;
		if (clr)
		begin
			s_nxt.cnt = inc_en ? {{(W-IW){1'b0}}, inc_amt} : '0;
			s_nxt.ovf = 1'b0;
		end
		else if (inc_en)
		begin
			if (sum[W])
			begin
				s_nxt.cnt = '1;       // stays at its maximum
				s_nxt.ovf = 1'b1;
			end
			else
				s_nxt.cnt = sum[W-1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign count = s_r.cnt;
	assign ovf   = s_r.ovf;

	a_clear_zero: assert property (@(posedge clk) disable iff (!resetn)
		clr && !inc_en |=> count == '0 && !ovf)
		else $error("counter not zero after clear");

endmodule

//--- rtl/peak_detect.sv
`timescale 1ns/10ps
module peak_detect
	import flow_pkg::*;
#(
	parameter int TENTH_CYC = TENTH_CYC_DEF
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// samples and settings
	input  wire logic              valid,
	input  wire logic [RATE_W-1:0] value,
	input  wire logic [RATE_W-1:0] swing,
	input  wire logic [7:0]        show_tenths,
	input  wire logic              hold_style,
	input  wire logic              esc,
	// held peak
	output logic                   peak_show,
	output logic      [RATE_W-1:0] peak_value
);

	if (TENTH_CYC < 2 || TENTH_CYC >= 2**TMR_W)
		$error("TENTH_CYC out of range");

	typedef struct packed {
		logic              falling;   // past a detected peak, watching the rise
		logic [RATE_W-1:0] ext;       // running extreme
		logic              show;
		logic [RATE_W-1:0] peak;
		logic [TMR_W-1:0]  tmr;
		logic [7:0]        tenths;
	} pk_t;

	pk_t  s_r;
	pk_t  s_nxt;
	logic detect;

	// a peak counts only after a drop of the full swing
	assign detect = valid && !s_r.falling && value <= s_r.ext
		&& (s_r.ext - value) >= swing;

	always_comb
	begin
		s_nxt = s_r;
		// track the extreme in the current direction
		if (valid)
		begin
			if (!s_r.falling)
			begin
				if (value > s_r.ext)
					s_nxt.ext = value;
				else if (detect)
				begin
					s_nxt.falling = 1'b1;
					s_nxt.ext     = value;
				end
			end
			else if (value < s_r.ext)
				s_nxt.ext = value;
			else if ((value - s_r.ext) >= swing)
			begin
				s_nxt.falling = 1'b0;   // rise of a full swing rearms
				s_nxt.ext     = value;
			end
		end
		// show time runs in tenths of a second
		if (s_r.show && show_tenths != 8'h00)
		begin
			if (s_r.tmr == TMR_W'(TENTH_CYC - 1))
			begin
				s_nxt.tmr    = '0;
				s_nxt.tenths = s_r.tenths + 8'h01;
				if (s_r.tenths + 8'h01 >= show_tenths)
					s_nxt.show = 1'b0;
			end
			else
				s_nxt.tmr = s_r.tmr + TMR_W'(1);
		end
		// zero time: hold until escape, or no holding at all
		if (s_r.show && show_tenths == 8'h00 && (esc || !hold_style))
			s_nxt.show = 1'b0;
		// a newer peak replaces the shown one and restarts the time
		if (detect && (show_tenths != 8'h00 || hold_style))
		begin
			s_nxt.show   = 1'b1;
			s_nxt.peak   = s_r.ext;
			s_nxt.tmr    = '0;
			s_nxt.tenths = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign peak_show  = s_r.show;
	assign peak_value = s_r.peak;

	a_peak_restart: assert property (@(posedge clk) disable iff (!resetn)
		detect && show_tenths != 8'h00 |=> peak_show && s_r.tmr == '0 && peak_value == $past(s_r.ext))
		else $error("new peak did not restart the show time");

endmodule

//--- rtl/flow_display.sv
`timescale 1ns/10ps
module flow_display
	import flow_pkg::*;
#(
	parameter int QV_CYC    = QV_CYC_DEF,
	parameter int HOLD_CYC  = HOLD_CYC_DEF,
	parameter int BLINK_CYC = BLINK_CYC_DEF,
	parameter int TENTH_CYC = TENTH_CYC_DEF
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// settings and samples
	input  wire cfg_t              cfg,
	input  wire meas_t             meas,
	input  wire logic [CNT_W-1:0]  thr1_value,
	// front panel
	input  wire btn_t              btn,
	// clear requests, one-cycle pulses
	input  wire logic              menu_clr_total,
	input  wire logic              clear_batcher_cmd,
	input  wire logic              prog_clr_total,
	input  wire logic              prog_clr_batcher,
	input  wire logic              host_tot_wr,
	input  wire logic              host_bat_wr,
	input  wire logic [15:0]       host_wdata,
	// batching
	input  wire logic              batch_start,
	input  wire logic              batch_run,
	// results
	output disp_t                  disp,
	output logic      [CNT_W-1:0]  total_value,
	output logic      [CNT_W-1:0]  batcher_value,
	output logic      [BCNT_W-1:0] batch_count
);

	if (QV_CYC < 2 || HOLD_CYC < 3 || BLINK_CYC < 2 || QV_CYC >= 2**TMR_W
		|| HOLD_CYC >= 2**TMR_W || BLINK_CYC >= 2**TMR_W)
		$error("timing parameter out of range");

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		view_t             view;
		logic [TMR_W-1:0]  blink_cnt;
		logic              blink;      // flash phase
		logic [TMR_W-1:0]  hold_cnt;   // totals button held time
		logic              armed;      // clear waits for enter
		logic              qv_on;      // quick view active
		logic              qv_item;    // 0: threshold one, 1: batch count
		logic [TMR_W-1:0]  qv_cnt;
		logic [1:0]        screen;     // six-digit screen of the total
		btn_t              btn_q;
		logic [BCNT_W-1:0] bcount;
		logic              started;    // batching started since zeroing
		disp_t             disp;
	} st_t;

	st_t               s_r;
	st_t               s_nxt;
	btn_t              press;          // rising edges of the buttons
	logic              release_tot;
	logic              confirm;
	logic              clr_tot;
	logic              clr_bat;
	logic              clr_bcnt;
	logic              tot_inc;
	logic              tot_ovf;
	logic              bat_ovf;
	logic [CUR_W-1:0]  cut_ua;
	logic              peak_show;
	logic [RATE_W-1:0] peak_value;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// cutoff current in microamps
	function automatic logic [CUR_W-1:0] cutoff_ua(input logic [6:0] pct, input logic r420);
		logic [15:0] p;
		p = {9'h000, pct};
		if (r420)
			cutoff_ua = CUR_W'(p * CUT_SPAN_420 + CUT_BASE_420);
		else
			cutoff_ua = CUR_W'(p * CUT_SPAN_020);
	endfunction

	// smallest total that needs the given screen
	function automatic logic [CNT_W-1:0] screen_lim(input logic [1:0] sc);
		case (sc)
			2'h1:    screen_lim = SCREEN_LIM1;
			2'h2:    screen_lim = SCREEN_LIM2;
			default: screen_lim = '0;
		endcase
	endfunction

	assign press       = btn_t'(btn & ~s_r.btn_q);
	assign release_tot = s_r.btn_q.total && !btn.total;
	assign confirm     = s_r.armed && press.enter;
	assign cut_ua      = cutoff_ua(cfg.cutoff_pct, cfg.range_4_20);

	////////////////////////////////////////////////////////////////////////////
	// counters; they run whatever the panel or the menu is doing

	// confirmed button clear hits what was on show when it was armed
	assign clr_bcnt = confirm && s_r.qv_on && s_r.qv_item;
	assign clr_tot  = menu_clr_total || prog_clr_total
		|| (host_tot_wr && host_wdata == 16'h0000)
		|| (confirm && !s_r.qv_on && s_r.view == V_TOTAL);
	assign clr_bat  = clear_batcher_cmd || prog_clr_batcher
		|| (host_bat_wr && host_wdata == 16'h0000)
		|| (confirm && !s_r.qv_on && s_r.view == V_BATCH);

	// no menu gating here, so programming never stops counting
	assign tot_inc = meas.sample_valid
		&& (cfg.cutoff_pct == 7'h00 || meas.current_ua >= cut_ua);

	sat_counter #(.W(CNT_W), .IW(INC_W)) u_total (
		.clk     (clk),
		.resetn  (resetn),
		.inc_en  (tot_inc),
		.inc_amt (meas.flow_increment),
		.clr     (clr_tot),
		.count   (total_value),
		.ovf     (tot_ovf)
	);

	sat_counter #(.W(CNT_W), .IW(INC_W)) u_batcher (
		.clk     (clk),
		.resetn  (resetn),
		.inc_en  (meas.sample_valid && batch_run),
		.inc_amt (meas.flow_increment),
		.clr     (clr_bat),
		.count   (batcher_value),
		.ovf     (bat_ovf)
	);

	peak_detect #(.TENTH_CYC(TENTH_CYC)) u_peak (
		.clk         (clk),
		.resetn      (resetn),
		.valid       (meas.sample_valid),
		.value       (meas.flow_rate),
		.swing       (cfg.peak_min_swing),
		.show_tenths (cfg.peak_show_tenths),
		.hold_style  (cfg.peak_display_style),
		.esc         (press.esc),
		.peak_show   (peak_show),
		.peak_value  (peak_value)
	);

	////////////////////////////////////////////////////////////////////////////
	// panel and display logic

	always_comb
	begin
		s_nxt       = s_r;
		s_nxt.btn_q = btn;
		// flash phase shared by every blinking element
		if (s_r.blink_cnt == TMR_W'(BLINK_CYC - 1))
		begin
			s_nxt.blink_cnt = '0;
			s_nxt.blink     = ~s_r.blink;
		end
		else
			s_nxt.blink_cnt = s_r.blink_cnt + TMR_W'(1);
		// batch starts: only the first after zeroing is counted
		if (clr_bcnt)
			s_nxt.bcount = '0;
		else if (batch_start && !s_r.started)
			s_nxt.bcount = s_r.bcount + BCNT_W'(1);
		if (batch_start)
			s_nxt.started = 1'b1;
		if (clr_bat && !batch_start)
			s_nxt.started = 1'b0;
		// totals button hold timer; arming by a hold needs the clear enabled
		if (press.total)
			s_nxt.hold_cnt = '0;
		else if (btn.total && s_r.hold_cnt != TMR_W'(HOLD_CYC - 1))
			s_nxt.hold_cnt = s_r.hold_cnt + TMR_W'(1);
		if (btn.total && !s_r.qv_on && s_r.hold_cnt == TMR_W'(HOLD_CYC - 2)
			&& ((s_r.view == V_TOTAL && cfg.button_clear_enable_tot)
			|| (s_r.view == V_BATCH && cfg.button_clear_enable_bat)))
			s_nxt.armed = 1'b1;
		// query answered by enter, dropped by esc, up or down; the totals button leaves it
		if (s_r.armed)
		begin
			if (press.enter || press.esc || press.up || press.down)
				s_nxt.armed = 1'b0;
		end
		else if (s_r.qv_on)
		begin
			// quick view: a press within the window advances
			if (press.total && s_r.qv_item)
				s_nxt.armed = 1'b1;
			else if (press.up || press.down)
			begin
				s_nxt.qv_item = ~s_r.qv_item;
				s_nxt.qv_cnt  = '0;
			end
			else if (s_r.qv_cnt == TMR_W'(QV_CYC - 1))
				s_nxt.qv_on = 1'b0;
			else
				s_nxt.qv_cnt = s_r.qv_cnt + TMR_W'(1);
		end
		else if (s_r.view == V_TOTAL)
		begin
			// screens of a long total
			if (press.up && s_r.screen != SCREEN_TOP
				&& total_value >= screen_lim(s_r.screen + 2'h1))
				s_nxt.screen = s_r.screen + 2'h1;
			else if (press.down && s_r.screen != 2'h0)
				s_nxt.screen = s_r.screen - 2'h1;
		end
		else if (press.up || press.down)
		begin
			s_nxt.qv_on   = 1'b1;
			s_nxt.qv_item = 1'b0;
			s_nxt.qv_cnt  = '0;
		end
		// a short press steps the view; a long one is a clear
		if (release_tot && !s_r.armed && !s_r.qv_on
			&& s_r.hold_cnt < TMR_W'(HOLD_CYC - 2))
		begin
			s_nxt.screen = 2'h0;
			case (s_r.view)
				V_RATE:  s_nxt.view = V_TOTAL;
				V_TOTAL: s_nxt.view = cfg.batcher_source ? V_BATCH : V_RATE;
				default: s_nxt.view = V_RATE;
			endcase
		end
		if (!cfg.batcher_source && s_nxt.view == V_BATCH)
			s_nxt.view = V_RATE;
		// a shrunken total cannot stay on an empty screen
		if (total_value < screen_lim(s_nxt.screen))
			s_nxt.screen = 2'h0;

		// display content, registered
		s_nxt.disp = '0;
		s_nxt.disp.total_led = (s_r.view == V_TOTAL)
			|| (s_r.view == V_BATCH && s_r.blink);
		if (s_r.armed)
			s_nxt.disp.msg = M_CLEAR_Q;
		else if (s_r.qv_on)
		begin
			// name and value alternate with the flash phase
			if (s_r.blink)
				s_nxt.disp.msg = s_r.qv_item ? M_BCNT_LBL : M_THR1_LBL;
			else
				s_nxt.disp.value = s_r.qv_item ? {{(CNT_W-BCNT_W){1'b0}}, s_r.bcount} : thr1_value;
		end
		else
		begin
			case (s_r.view)
				V_TOTAL:
				begin
					if (tot_ovf && s_r.blink)
						s_nxt.disp.msg = M_TOVF;
					s_nxt.disp.value    = total_value;
					s_nxt.disp.screen   = s_r.screen;
					s_nxt.disp.dp_left  = s_r.blink && s_r.screen != SCREEN_TOP
						&& total_value >= screen_lim(s_r.screen + 2'h1);
					s_nxt.disp.dp_right = s_r.blink && s_r.screen != 2'h0;
				end
				V_BATCH:
				begin
					if (bat_ovf && s_r.blink)
						s_nxt.disp.msg = M_BOVF;
					s_nxt.disp.value   = batcher_value;
					s_nxt.disp.dp_left = s_r.blink && batcher_value >= SCREEN_LIM1;
				end
				default:
				begin
					if (meas.range_high)
						s_nxt.disp.msg = M_RHIGH;
					else if (meas.range_low)
						s_nxt.disp.msg = M_RLOW;
					else if (cfg.period_mode)
					begin
						if (meas.flow_rate == '0)
							s_nxt.disp.msg = M_STOP;
						else if (meas.period_value > SIX_DIG_MAX)
							s_nxt.disp.msg = M_POVER;
						else if (meas.period_value == '0)
							s_nxt.disp.msg = M_PUNDER;
						else
							s_nxt.disp.value = {{(CNT_W-RATE_W){1'b0}}, meas.period_value};
					end
					else if (peak_show)
					begin
						s_nxt.disp.value    = {{(CNT_W-RATE_W){1'b0}}, peak_value};
						s_nxt.disp.dp_right = s_r.blink;
					end
					else
						s_nxt.disp.value = {{(CNT_W-RATE_W){1'b0}}, meas.flow_rate};
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign disp        = s_r.disp;
	assign batch_count = s_r.bcount;

	////////////////////////////////////////////////////////////////////////////
	// checks

	// plain rate view with no range warning pending
	logic live_rate;
	assign live_rate = !s_r.armed && !s_r.qv_on && s_r.view == V_RATE && !meas.range_high && !meas.range_low;

	a_stop_msg: assert property (@(posedge clk) disable iff (!resetn)
		live_rate && (cfg.period_mode && meas.flow_rate == '0) |=> disp.msg == M_STOP)
		else $error("zero flow in period view not shown as stop");

	a_over_msg: assert property (@(posedge clk) disable iff (!resetn)
		live_rate && (cfg.period_mode && meas.flow_rate != '0 && meas.period_value > SIX_DIG_MAX)
		|=> disp.msg == M_POVER)
		else $error("long period not shown as overload");

	a_under_msg: assert property (@(posedge clk) disable iff (!resetn)
		live_rate && (cfg.period_mode && meas.flow_rate != '0 && meas.period_value == '0)
		|=> disp.msg == M_PUNDER)
		else $error("short period not shown as underload");

	a_range_high: assert property (@(posedge clk) disable iff (!resetn)
		!s_r.armed && !s_r.qv_on && s_r.view == V_RATE && meas.range_high |=> disp.msg == M_RHIGH)
		else $error("range high warning missing");

	a_cutoff_hold: assert property (@(posedge clk) disable iff (!resetn)
		meas.sample_valid && cfg.cutoff_pct != 7'h00 && meas.current_ua < cut_ua && !clr_tot
		|=> $stable(total_value))
		else $error("total counted below cutoff");

	a_total_led: assert property (@(posedge clk) disable iff (!resetn)
		s_r.view == V_TOTAL ##1 s_r.view == V_TOTAL |-> disp.total_led)
		else $error("totals led not lit in total view");

	a_bat_view: assert property (@(posedge clk) disable iff (!resetn)
		!cfg.batcher_source |=> s_r.view != V_BATCH)
		else $error("batcher view without batcher operation");

	a_batch_once: assert property (@(posedge clk) disable iff (!resetn)
		batch_start && s_r.started && !clr_bcnt |=> batch_count == $past(batch_count))
		else $error("batch count rose on a restart");

	a_qv_timeout: assert property (@(posedge clk) disable iff (!resetn)
		s_r.qv_on && !s_r.armed && s_r.qv_cnt == TMR_W'(QV_CYC - 1) && !btn.up && !btn.down
		&& !press.total |=> !s_r.qv_on)
		else $error("quick view did not time out");

endmodule

//--- sim/panel_model.sv
`timescale 1ns/10ps
// operator at the panel: holds one button pattern for a set time
module panel_model
	import flow_pkg::*;
(
	// clock
	input  wire logic       clk,
	// request from the bench
	input  wire logic       go,
	input  wire btn_t       which,
	input  wire logic [7:0] len,
	// panel levels
	output btn_t            btn,
	output logic            busy
);
	logic [7:0] n_r = 8'h00; // cycles left to hold
	// a long hold arms a clear, a later enter confirms
	always_ff @(posedge clk)
	begin
		if (go)
			n_r <= len;
		else if (n_r != 8'h00)
			n_r <= n_r - 8'h01;
	end
	// released buttons read as not pressed
	assign busy = go || (n_r != 8'h00);
	assign btn  = (busy && !go) ? which : '0;
endmodule

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench;
	import flow_pkg::*;
	logic             clk = 1'b0;
	logic             resetn = 1'b0;
	cfg_t             cfg;
	meas_t            ms;
	btn_t             pw;
	btn_t             btn;
	logic             go;
	logic             busy;
	logic [7:0]       pl;
	logic [6:0]       p;      // clear and start pulses
	logic [15:0]      hw;
	disp_t            d;
	logic [CNT_W-1:0] tv, bv, et, eb;
	logic [15:0]      bc;
	logic             br = 1'b1;   // batcher counting enable
	int               nl, nv;      // hit counts over a window
	logic [31:0]      lf = 32'h95F6;
	int               bad_count = 0;
	int               total_checks = 0;
	initial forever #10 clk = ~clk;
	////////////////////////////////////////
	flow_display #(.QV_CYC(40), .HOLD_CYC(20), .BLINK_CYC(4), .TENTH_CYC(4)) dut_u (
		.clk(clk), .resetn(resetn), .cfg(cfg), .meas(ms), .thr1_value(48'h0000000000AB), .btn(btn),
		.menu_clr_total(p[0]), .prog_clr_total(p[1]), .host_tot_wr(p[2]), .clear_batcher_cmd(p[3]),
		.prog_clr_batcher(p[4]), .host_bat_wr(p[5]), .batch_start(p[6]), .host_wdata(hw),
		.batch_run(br), .disp(d), .total_value(tv), .batcher_value(bv), .batch_count(bc));
	panel_model pm_u (.clk(clk), .go(go), .which(pw), .len(pl), .btn(btn), .busy(busy));
	////////////////////////////////////////
	// lfsr step, repeatable random data
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// cutoff in microamps
	function automatic logic [15:0] cut(input cfg_t c);
		return c.range_4_20 ? 16'(c.cutoff_pct * 160 + 4000) : 16'(c.cutoff_pct * 200);
	endfunction
	task automatic chk(input logic [CNT_W-1:0] s, input logic [CNT_W-1:0] e);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one-cycle pulse on clear or start line i
	task automatic pul(input int i, input logic [15:0] w);
		@(posedge clk);
		p <= 7'(1 << i);
		hw <= w;
		@(posedge clk);
		p <= '0;
	endtask
	// one sample; below cutoff the total stays
	task automatic smp(input logic [14:0] c, input logic [15:0] f, input logic [23:0] r, q, input logic [1:0] hl);
		@(posedge clk);
		ms <= {1'b1, c, r, q, f, hl};
		@(posedge clk);
		ms.sample_valid <= 1'b0;
		if (cfg.cutoff_pct == 0 || c >= cut(cfg))
			et = et + f;
		if (br)
			eb = eb + f;
	endtask
	// period view message for given flow and period
	task automatic pc(input logic [1:0] hl, input logic [23:0] r, q, input msg_t m);
		smp(15'd100, 16'h0000, r, q, hl);
		repeat (2) @(posedge clk);
		#1 chk(48'(d.msg), 48'(m));
	endtask
	// press a button pattern, wait for release, three cycles to show
	task automatic press(input btn_t w, input logic [7:0] n);
		@(posedge clk);
		go <= 1'b1;
		pw <= w;
		pl <= n;
		@(posedge clk);
		go <= 1'b0;
		for (int k = 0; busy && k < 300; k++) @(posedge clk);
		if (busy)
		begin
			bad_count++;
			print_verdict();
		end
		repeat (3) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////
	// eight cycles of quick view: name and value share the time
	task automatic qvc(input msg_t l, input logic [CNT_W-1:0] v);
		nl = 0;
		nv = 0;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk) #1;
			nl += (d.msg == l);
			nv += (d.value == v);
		end
		chk(48'(nl), 48'h4);
		chk(48'(nv), 48'h4);
	endtask
	initial
	begin
		cfg = '0;
		cfg.period_mode = 1'b1;
		cfg.range_4_20 = 1'b1;
		cfg.cutoff_pct = 7'd10;
		cfg.batcher_source = 1'b1;
		cfg.button_clear_enable_tot = 1'b1;
		{ms, pw, go, pl, p, hw, et, eb} = '0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		smp(15'd5600, 16'h0003, 24'h10, 24'h20, 2'b00); // cutoff edge
		smp(15'd5599, 16'h0005, 24'h10, 24'h20, 2'b00);
		for (int k = 0; k < 40; k++)
		begin
			lf = nx(lf);
			smp(15'(lf[15:0] % 16'd12000), {8'h00, lf[23:16]}, 24'h10, 24'h20, 2'b00);
		end
		@(posedge clk) #1 chk(tv, et);
		for (int i = 0; i < 6; i++)
		begin
			smp(15'd9000, 16'h0011, 24'h10, 24'h20, 2'b00);
			pul(i, 16'h0000);
			if (i < 3) et = '0; else eb = '0;
			@(posedge clk) #1 chk(tv, et);
			chk(bv, eb);
		end
		smp(15'd9000, 16'h0011, 24'h10, 24'h20, 2'b00);
		pul(2, 16'h0001);
		@(posedge clk) #1 chk(tv, et);
		br <= 1'b0;
		smp(15'd9000, 16'h0011, 24'h10, 24'h20, 2'b00); // batcher idle
		br <= 1'b1;
		@(posedge clk) #1 chk(tv, et);
		chk(bv, eb);
		pul(6, '0);
		pul(6, '0);
		pul(3, '0);
		pul(6, '0);
		@(posedge clk) #1 chk(48'(bc), 48'h2);
		pc(2'b00, 24'h0, 24'h5, M_STOP);
		pc(2'b00, 24'h7, 24'hF4240, M_POVER);
		pc(2'b00, 24'h7, 24'h0, M_PUNDER);
		pc(2'b00, 24'h7, 24'hF423F, M_VALUE);
		pc(2'b10, 24'h7, 24'h5, M_RHIGH);
		pc(2'b01, 24'h7, 24'h5, M_RLOW);
		press(5'b10000, 8'd2);
		chk(48'(d.total_led), 48'h1);
		press(5'b10000, 8'd25);
		chk(48'(d.msg), 48'(M_CLEAR_Q));
		press(5'b01000, 8'd2);
		chk(tv, '0);
		repeat (16) smp(15'd9000, 16'hFFFF, 24'h10, 24'h20, 2'b00);
		press(5'b00100, 8'd2);
		chk(48'(d.screen), 48'h1);
		press(5'b10000, 8'd2);
		press(5'b10000, 8'd2);
		chk(48'(d.total_led), 48'h0);
		press(5'b00100, 8'd2);
		qvc(M_THR1_LBL, 48'h0000000000AB);
		press(5'b00100, 8'd2);
		qvc(M_BCNT_LBL, 48'h000000000002);
		press(5'b10000, 8'd2);
		press(5'b01000, 8'd2);
		chk(48'(bc), 48'h0);
		repeat (45) @(posedge clk);
		cfg.period_mode <= 1'b0;
		cfg.peak_min_swing <= 24'h10;
		cfg.peak_show_tenths <= 8'h02;
		smp(15'd9000, 16'h0001, 24'h50, 24'h20, 2'b00);
		smp(15'd9000, 16'h0001, 24'h80, 24'h20, 2'b00);
		smp(15'd9000, 16'h0001, 24'h60, 24'h20, 2'b00); // drop of twice the swing
		nl = 0;
		nv = 0;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk) #1;
			nl += d.dp_right;
			nv += (d.value == 48'h000000000080);
		end
		chk(48'(nv), 48'h8);
		chk(48'(nl), 48'h4);
		repeat (4) @(posedge clk);
		#1 chk(d.value, 48'h000000000060);
		print_verdict();
	end
endmodule
